/* dv/host_model.sv */
// Purpose: Host controller model framing instruction bytes
// Assumes: Spacing of three cycles or more for the synchronisers
// Notes:   Released data line shows the inverse of its last value
`timescale 1ns/10ps

module host_model (
   // Pins toward the block
   input  wire logic       ref_clk,
   output logic            frame_pin,
   output logic            byte_pin,
   output logic      [7:0] byte_data
);
   // Idle pins at time zero
   initial begin
      frame_pin = 1'b0;
      byte_pin  = 1'b0;
      byte_data = 8'h00;
   end

   // Wait n rising edges
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : step

   // One frame: opcode, then nd data bytes, d first and extras as the inverse
   task automatic frame(input logic [7:0] op, input int nd, input logic [7:0] d,
                        input int slow);
      frame_pin <= 1'b1;
      step(3 + slow);
      for (int i = 0; i <= nd; i++) begin
         byte_data <= (i == 0) ? op : (i == 1) ? d : ~d;
         byte_pin  <= 1'b1;
         step(4 + slow);
         byte_pin  <= 1'b0;
         byte_data <= ~byte_data;
         step(4);
      end
      frame_pin <= 1'b0;
      step(4 + slow);
   endtask : frame
endmodule : host_model

/* dv/test_flash_addr_ctrl.sv */
// Purpose: Self-checking bench for address mode and reset control
// Assumes: Host model spaces every byte and frame
// Notes:   Pulses are counted by a monitor process
`timescale 1ns/10ps
`include "flash_addr_consts.svh"
`define CHECK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
   bad_count++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end

module test_flash_addr_ctrl;
   localparam logic [31:0] HA = 32'h9ABC_DEF1;
   localparam logic [31:0] HB = 32'h1357_2468;
   logic ref_clk, resetn, hw_reset_n, frame_pin, byte_pin, read_valid;
   logic four_byte_mode, write_enable, soft_reset_pulse;
   logic [7:0] byte_data, ext_addr, status_out, read_byte, rd_last;
   logic [31:0] array_addr, host_addr;
   int bad_count = 0, cmp_count = 0, rd_seen = 0, rst_seen = 0, cyc = 0;

   host_model h (.ref_clk(ref_clk), .frame_pin(frame_pin), .byte_pin(byte_pin),
                 .byte_data(byte_data));
   flash_addr_ctrl flash_addr_ctrl_i (.ref_clk(ref_clk), .resetn(resetn),
      .hw_reset_n(hw_reset_n), .frame_pin(frame_pin), .byte_pin(byte_pin),
      .byte_data(byte_data), .host_addr(host_addr), .array_addr(array_addr),
      .four_byte_mode(four_byte_mode), .ext_addr(ext_addr), .status_out(status_out),
      .write_enable(write_enable), .read_byte(read_byte), .read_valid(read_valid),
      .soft_reset_pulse(soft_reset_pulse));

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Pulse monitor and timeout
   always @(posedge ref_clk) begin
      cyc++;
      if (read_valid === 1'b1) begin
         rd_seen++;
         rd_last = read_byte;
      end
      if (soft_reset_pulse === 1'b1) rst_seen++;
      if (cyc == 5000) begin
         bad_count++;
         close_out();
      end
   end

   // Verdict
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   // Mode switches need no write enable
   task automatic t_mode();
      h.frame(`OP_ENTER_4BYTE, 0, 8'h00, 0);
      `CHECK("mode", 1'b1, four_byte_mode)
      `CHECK("addr4", HA, array_addr)
      h.frame(`OP_EXIT_4BYTE, 0, 8'h00, 2);
      `CHECK("mode", 1'b0, four_byte_mode)
   endtask : t_mode

   // Extended register write, extra byte, read back
   task automatic t_ext();
      h.frame(`OP_WRITE_EXT_ADDR, 2, 8'hA5, 0);
      `CHECK("ext", 8'hA5, ext_addr)
      `CHECK("addr3", {8'hA5, HA[23:0]}, array_addr)
      host_addr <= HB;
      h.step(1);
      `CHECK("addr3b", {8'hA5, HB[23:0]}, array_addr)
      h.frame(`OP_READ_EXT_ADDR, 0, 8'h00, 1);
      `CHECK("rdcnt", 1, rd_seen)
      `CHECK("rdbyte", 8'hA5, rd_last)
      h.frame(`OP_WRITE_EXT_ADDR, 1, 8'h00, 0);
      `CHECK("seg0", {8'h00, HB[23:0]}, array_addr)
   endtask : t_ext

   // Status write gated by write enable, kept over reset
   task automatic t_status();
      h.frame(`OP_WRITE_ENABLE, 0, 8'h00, 0);
      `CHECK("wel", 1'b1, write_enable)
      h.frame(`OP_WRITE_STATUS, 1, 8'h5C, 0);
      `CHECK("stat", 8'h5C, status_out)
      h.frame(`OP_WRITE_STATUS, 1, 8'hA3, 0);
      `CHECK("stat", 8'h5C, status_out)
      h.frame(`OP_WRITE_ENABLE, 0, 8'h00, 0);
      `CHECK("statwel", 8'h5E, status_out)
      h.frame(`OP_WRITE_DISABLE, 0, 8'h00, 0);
      `CHECK("wel", 1'b0, write_enable)
      h.frame(`OP_WRITE_STATUS, 1, 8'h33, 0);
      `CHECK("stat", 8'h5C, status_out)
      h.frame(`OP_READ_STATUS, 0, 8'h00, 0);
      `CHECK("rdcnt", 2, rd_seen)
      `CHECK("rdstat", 8'h5C, rd_last)
      resetn <= 1'b0;
      h.step(3);
      resetn <= 1'b1;
      h.step(4);
      `CHECK("stat", 8'h5C, status_out)
   endtask : t_status

   // Software reset needs the enable first
   task automatic t_soft();
      h.frame(`OP_ENTER_4BYTE, 0, 8'h00, 0);
      h.frame(`OP_WRITE_EXT_ADDR, 1, 8'h7E, 0);
      h.frame(`OP_WRITE_ENABLE, 0, 8'h00, 0);
      h.frame(`OP_RESET, 0, 8'h00, 0);
      `CHECK("mode", 1'b1, four_byte_mode)
      `CHECK("pulse", 0, rst_seen)
      `CHECK("addr4", HB, array_addr)
      h.frame(`OP_RESET_ENABLE, 0, 8'h00, 0);
      h.frame(`OP_RESET, 0, 8'h00, 0);
      `CHECK("pulse", 1, rst_seen)
      `CHECK("wel", 1'b0, write_enable)
      `CHECK("mode", 1'b0, four_byte_mode)
      `CHECK("ext", 8'h00, ext_addr)
   endtask : t_soft

   // Hardware reset pin
   task automatic t_hw();
      h.frame(`OP_ENTER_4BYTE, 0, 8'h00, 0);
      h.frame(`OP_WRITE_EXT_ADDR, 1, 8'h11, 0);
      hw_reset_n <= 1'b0;
      h.step(4);
      hw_reset_n <= 1'b1;
      h.step(4);
      `CHECK("mode", 1'b0, four_byte_mode)
      `CHECK("ext", 8'h00, ext_addr)
   endtask : t_hw

   // Main sequence
   initial begin
      resetn     = 1'b0;
      hw_reset_n = 1'b1;
      host_addr  = HA;
      h.step(10);
      resetn <= 1'b1;
      h.step(4);
      `CHECK("mode", 1'b0, four_byte_mode)
      `CHECK("ext", 8'h00, ext_addr)
      `CHECK("wel", 1'b0, write_enable)
      t_mode();
      t_ext();
      t_status();
      t_soft();
      t_hw();
      close_out();
   end
endmodule : test_flash_addr_ctrl

/* hw/flash_addr_consts.svh */
// Purpose: Constants for the flash address mode and reset control block
// Assumes: Byte-wide instruction stream already framed by the serial front end
// Notes:   Timing is in ref_clk cycles
// Notes on behaviour
// - Status register one is non-volatile and powers up to last written value.
// - Status write is refused unless write enable was set beforehand.
// - Software reset needs reset-enable then reset; device returns to power-on state.
// - Exit-four-byte instruction returns to 3-byte addressing, no write enable needed.
// - Enter-four-byte instruction selects 4-byte addressing, no write enable needed.
// - An 8-bit volatile extended address register supplies address bits 31 to 24; the code uses it in 3-byte mode only, host_addr in 4-byte mode.
// - Extended register read by its read instruction, written with exactly one byte.
// - Hardware reset, software reset or power cycle return to 3-byte addressing.
`ifndef FLASH_ADDR_CONSTS_SVH
`define FLASH_ADDR_CONSTS_SVH

// ----------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_WRITE_STATUS   8'h01
`define OP_READ_STATUS    8'h05
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99
`define OP_EXIT_4BYTE     8'hE9
`define OP_ENTER_4BYTE    8'hB7
`define OP_READ_EXT_ADDR  8'hC8
`define OP_WRITE_EXT_ADDR 8'hC5

// ----------------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------------
`define EXT_ADDR_RESET    8'h00
`define STATUS_WEL_BIT    1
`define NVM_DEPTH         4
`define NVM_STATUS_INDEX  2'h0

`endif

/* hw/flash_addr_ctrl.sv */
// Purpose: Address mode, extended address, software reset and status write control
// Assumes: Front end delivers bytes with a strobe level, edge-detected here to one cycle, and frame level from pins
// Notes:   Frame, byte strobe and byte data each pass two flip-flops before use
`timescale 1ns/10ps
`include "flash_addr_consts.svh"

module flash_addr_ctrl
   import flash_addr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Hardware reset pin
   input  wire logic        hw_reset_n,
   // Byte stream from serial front end
   input  wire logic        frame_pin,
   input  wire logic        byte_pin,
   input  wire logic [7:0]  byte_data,
   // Address from front end
   input  wire logic [31:0] host_addr,
   // Outputs
   output logic [31:0]      array_addr,
   output logic             four_byte_mode,
   output logic [7:0]       ext_addr,
   output logic [7:0]       status_out,
   output logic             write_enable,
   output logic [7:0]       read_byte,
   output logic             read_valid,
   output logic             soft_reset_pulse
);

   // ----------------------------------------------------------------------
   // Module state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] frame_sync;
      logic [1:0] byte_sync;
      logic [1:0] hwrst_sync;
      logic       byte_seen;
      logic [7:0] data_meta;
      logic [7:0] data_hold;
      cmd_state_t state;
      logic       reset_armed;
      logic       four_byte;
      logic [7:0] ext;
      logic       wel;
      logic [7:0] rd_byte;
      logic       rd_valid;
      logic       sw_reset;
      logic       nvm_wr;
      logic [7:0] nvm_data;
   } ctrl_state_t;

   ctrl_state_t s_reg;
   ctrl_state_t s_next;
   logic [7:0]  nvm_rd;
   logic        frame_on;
   logic        byte_stb;
   logic        hw_rst;

   // Status byte store, kept across resets
   status_nvm u_nvm (
      .ref_clk (ref_clk),
      .wr_en   (s_reg.nvm_wr),
      .wr_addr (`NVM_STATUS_INDEX),
      .wr_data (s_reg.nvm_data),
      .rd_addr (`NVM_STATUS_INDEX),
      .rd_data (nvm_rd)
   );

   // Synchronised pin views from the second stage, byte strobe edge-detected against byte_seen
   assign frame_on = s_reg.frame_sync[1];
   assign byte_stb = s_reg.byte_sync[1] & ~s_reg.byte_seen;
   assign hw_rst   = ~s_reg.hwrst_sync[1];

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_next            = s_reg;
      s_next.frame_sync = {s_reg.frame_sync[0], frame_pin};
      s_next.byte_sync  = {s_reg.byte_sync[0], byte_pin};
      s_next.hwrst_sync = {s_reg.hwrst_sync[0], hw_reset_n};
      s_next.byte_seen  = s_reg.byte_sync[1];
      // Byte data is a pin too, so it gets two stages like the strobe
      s_next.data_meta  = byte_data;
      s_next.data_hold  = s_reg.data_meta;
      s_next.rd_valid   = 1'b0;
      s_next.sw_reset   = 1'b0;
      s_next.nvm_wr     = 1'b0;
      if (!frame_on) begin
         s_next.state = ST_IDLE;
      end else if (byte_stb) begin
         case (s_reg.state)
            ST_IDLE: begin
               s_next.state = ST_OPCODE_DONE;
               // Any opcode other than reset enable disarms the reset sequence
               s_next.reset_armed = 1'b0;
               case (s_reg.data_hold)
                  `OP_WRITE_ENABLE:  s_next.wel = 1'b1;
                  `OP_WRITE_DISABLE: s_next.wel = 1'b0;
                  `OP_RESET_ENABLE:  s_next.reset_armed = 1'b1;
                  `OP_RESET: begin
                     if (s_reg.reset_armed) begin
                        s_next.sw_reset = 1'b1;
                     end
                  end
                  `OP_EXIT_4BYTE:  s_next.four_byte = 1'b0;
                  `OP_ENTER_4BYTE: s_next.four_byte = 1'b1;
                  `OP_READ_EXT_ADDR: begin
                     s_next.rd_byte  = s_reg.ext;
                     s_next.rd_valid = 1'b1;
                     s_next.state    = ST_IGNORE;
                  end
                  `OP_READ_STATUS: begin
                     s_next.rd_byte  = status_out;
                     s_next.rd_valid = 1'b1;
                     s_next.state    = ST_IGNORE;
                  end
                  `OP_WRITE_EXT_ADDR: s_next.state = ST_EXT_DATA;
                  `OP_WRITE_STATUS: begin
                     // Refused without a prior write enable
                     s_next.state = s_reg.wel ? ST_STATUS_DATA : ST_IGNORE;
                  end
                  default: s_next.state = ST_IGNORE;
               endcase
            end
            ST_EXT_DATA: begin
               s_next.ext   = s_reg.data_hold;
               s_next.state = ST_IGNORE;
            end
            ST_STATUS_DATA: begin
               s_next.nvm_wr   = 1'b1;
               s_next.nvm_data = s_reg.data_hold;
               s_next.wel      = 1'b0;
               s_next.state    = ST_IGNORE;
            end
            default: s_next.state = ST_IGNORE;
         endcase
      end
      // Mode, extended register, write enable and reset arm to power-on values; decoder to ST_IGNORE
      if (s_reg.sw_reset || hw_rst) begin
         s_next.four_byte   = 1'b0;
         s_next.ext         = `EXT_ADDR_RESET;
         s_next.wel         = 1'b0;
         s_next.reset_armed = 1'b0;
         s_next.state       = ST_IGNORE;
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         s_reg            <= '0;
         s_reg.hwrst_sync <= 2'h3;
         s_reg.state      <= ST_IDLE;
         s_reg.ext        <= `EXT_ADDR_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign four_byte_mode   = s_reg.four_byte;
   assign ext_addr         = s_reg.ext;
   assign write_enable     = s_reg.wel;
   assign status_out       = {nvm_rd[7:2], s_reg.wel, nvm_rd[0]};
   assign read_byte        = s_reg.rd_byte;
   assign read_valid       = s_reg.rd_valid;
   assign soft_reset_pulse = s_reg.sw_reset;
   // Upper byte from extended register in 3-byte mode
   assign array_addr = s_reg.four_byte ? host_addr : {s_reg.ext, host_addr[23:0]};

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   a_status_needs_wel: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_reg.nvm_wr |-> $past(s_reg.wel, 2)) else $error("status written without enable");
   a_reset_sequence: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_reg.sw_reset |-> $past(s_reg.reset_armed)) else $error("reset without enable");
   a_exit_four: assert property (@(posedge ref_clk) disable iff (!resetn)
      (byte_stb && frame_on && s_reg.state == ST_IDLE && s_reg.data_hold == `OP_EXIT_4BYTE)
      |=> !s_reg.four_byte) else $error("exit four byte failed");
   a_enter_four: assert property (@(posedge ref_clk) disable iff (!resetn)
      (byte_stb && frame_on && s_reg.state == ST_IDLE && s_reg.data_hold == `OP_ENTER_4BYTE
       && !hw_rst) |=> s_reg.four_byte) else $error("enter four byte failed");
   a_ext_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      (byte_stb && frame_on && s_reg.state == ST_EXT_DATA && !hw_rst && !s_reg.sw_reset)
      |=> s_reg.ext == $past(s_reg.data_hold)) else $error("ext write lost");
   a_reset_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
      (s_reg.sw_reset || hw_rst) |=> (!s_reg.four_byte && s_reg.ext == 8'h00))
      else $error("reset left mode set");
   a_addr_join: assert property (@(posedge ref_clk) disable iff (!resetn)
      !four_byte_mode |-> array_addr[31:24] == ext_addr) else $error("bad upper byte");
   a_ext_read: assert property (@(posedge ref_clk) disable iff (!resetn)
      (byte_stb && frame_on && s_reg.state == ST_IDLE && s_reg.data_hold == `OP_READ_EXT_ADDR)
      |=> (read_valid && read_byte == $past(s_reg.ext))) else $error("ext read wrong");

endmodule : flash_addr_ctrl

/* hw/flash_addr_pkg.sv */
// Purpose: Types for the flash address mode and reset control block
// Assumes: Constants come from flash_addr_consts.svh
// Notes:   Holds the state machine type only
package flash_addr_pkg;

   // ----------------------------------------------------------------------
   // Command decode states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE_DONE,
      ST_EXT_DATA,
      ST_STATUS_DATA,
      ST_IGNORE
   } cmd_state_t;

endpackage : flash_addr_pkg

/* hw/status_nvm.sv */
// Purpose: Small non-volatile store holding the status register byte
// Assumes: Contents model non-volatile cells, untouched by any reset
// Notes:   Read data comes out of a register
`timescale 1ns/10ps
`include "flash_addr_consts.svh"

module status_nvm (
   // Clock
   input  wire logic       ref_clk,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [1:0] wr_addr,
   input  wire logic [7:0] wr_data,
   // Read port
   input  wire logic [1:0] rd_addr,
   output logic      [7:0] rd_data
);

   logic [7:0] cells [`NVM_DEPTH];

   // ----------------------------------------------------------------------
   // Storage, no reset so value survives power and reset cycles
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
      rd_data <= cells[rd_addr];
   end

endmodule : status_nvm
